// [design/ahipm_pkg.sv]
package ahipm_pkg;

	// Result and bus widths.
	localparam int RES_W = 16;
	localparam int PAIR_W = 32;
	localparam int BUS_W = 16;

	// Positions of the shared functions on the data bus.
	localparam int PIN_GND0 = 8;
	localparam int PIN_GND1 = 9;
	localparam int PIN_SDI = 10;
	localparam int PIN_SERIAL_OUT_B = 11;
	localparam int PIN_SERIAL_OUT_A = 12;
	localparam int PIN_OS_LSB = 13;
	localparam int OS_W = 3;

	// Device input vector layout, bus bits at the bottom.
	localparam int IN_WR = 16;
	localparam int IN_SCLK = 17;
	localparam int IN_CS = 18;
	localparam int IN_FMT = 19;
	localparam int IN_SWM = 20;
	localparam int IN_W = 21;

	// Cycles after reset release before the straps are taken.
	localparam logic [2:0] STRAP_SETTLE = 3'h4;
	// Bits in one serial frame.
	localparam logic [4:0] SER_BITS = 5'h10;
	localparam logic [3:0] SER_LAST = 4'hF;

	// Fields of the software configuration word.
	localparam int CFGW_OS_LSB = 0;
	localparam int CFGW_BURST = 3;

	// Host register offsets on APB.
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CMD = 8'h04;
	localparam logic [7:0] ADDR_CFG = 8'h08;
	localparam logic [7:0] ADDR_STAT = 8'h0C;
	localparam logic [7:0] ADDR_RES = 8'h10;

	// Host control fields.
	localparam int CTRL_SER = 0;
	localparam int CTRL_SW = 1;
	localparam int CTRL_BURST = 2;
	localparam int CTRL_OS_LSB = 3;
	localparam int CTRL_W = 6;

	// Host command and status bits.
	localparam int CMD_READ = 0;
	localparam int CMD_WRITE = 1;
	localparam int STAT_BUSY = 0;
	localparam int STAT_VALID = 1;

	// Host link timing: half a serial clock period.
	localparam int CLK_PERIOD_NS = 10;
	localparam int SCLK_HALF_NS = 80;
	localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;

	// Host sequencer states.
	typedef enum logic [6:0] {
		HS_IDLE = 7'h01,
		HS_LEAD = 7'h02,
		HS_SLO = 7'h04,
		HS_SHI = 7'h08,
		HS_PLO = 7'h10,
		HS_PHI = 7'h20,
		HS_TAIL = 7'h40
	} ahipm_hstate_t;

endpackage

// [design/ahipm_link_if.sv]
`timescale 1ns/100ps
interface ahipm_link_if;

	// Mode straps driven by the host board side.
	logic link_format_select;
	logic config_by_software;
	// Framing and strobes.
	logic cs_n;
	logic sclk_rd;
	logic wr_burst;
	// Shared data bus, one driver set per end.
	logic [15:0] db_dev_o;
	logic [15:0] db_dev_oe;
	logic [15:0] db_host_o;
	logic [15:0] db_host_oe;
	logic [15:0] db;

	// Resolved bus level; an undriven line is pulled to ground.
	assign db = (db_dev_o & db_dev_oe) |
		(db_host_o & db_host_oe & ~db_dev_oe);

	modport dev (
		input link_format_select,
		input config_by_software,
		input cs_n,
		input sclk_rd,
		input wr_burst,
		input db,
		output db_dev_o,
		output db_dev_oe
	);

	modport host (
		output link_format_select,
		output config_by_software,
		output cs_n,
		output sclk_rd,
		output wr_burst,
		output db_host_o,
		output db_host_oe,
		input db
	);

endinterface

// [design/ahipm_fifo.sv]
`timescale 1ns/100ps
module ahipm_fifo #(
	parameter int W = 32,
	parameter int DEPTH = 4
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Filling side.
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// Draining side.
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);

	localparam int AW = $clog2(DEPTH);

	// Depth must be a power of two so the pointers wrap by themselves.
	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || W < 1) begin : g_chk
			$error("ahipm_fifo: DEPTH must be a power of two of 2 or more");
		end
	endgenerate

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
		logic full;
	} ahipm_fifo_st_t;

	ahipm_fifo_st_t q, d;
	logic push;
	logic pop;

	// Flags come from registered state so the source sees honest full.
	assign in_ready = ~q.full;
	assign out_valid = (q.cnt != '0);
	assign out_data = q.mem[q.rp];

	// Pointer and count update.
	always_comb begin
		d = q;
		push = in_valid & ~q.full;
		pop = out_ready & (q.cnt != '0);
		if (push) begin
			d.mem[q.wp] = in_data;
			d.wp = q.wp + 1'b1;
		end
		if (pop) begin
			d.rp = q.rp + 1'b1;
		end
		if (push && !pop) begin
			d.cnt = q.cnt + 1'b1;
		end else if (pop && !push) begin
			d.cnt = q.cnt - 1'b1;
		end
		d.full = (d.cnt == (AW + 1)'(DEPTH));
	end

	// State register, frozen while the clock enable is low.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else if (ce) begin
			q <= d;
		end
	end

endmodule

// [design/ahipm_dev.sv]
`timescale 1ns/100ps
module ahipm_dev #(
	parameter int FIFO_DEPTH = 4
) (
	// Clock, reset and clock enable.
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CE,
	// Link towards the host.
	ahipm_link_if.dev LINK,
	// Conversion result pairs, channel A in the upper half.
	input wire logic RES_VALID,
	output logic RES_READY,
	input wire logic [31:0] RES_DATA,
	// Latched mode and settings.
	output logic STRAPS_TAKEN,
	output logic SERIAL_MODE,
	output logic SW_CONFIG,
	output logic [2:0] OVERSAMPLE_RATIO,
	output logic BURST_ENABLE,
	// Configuration word written by the host.
	output logic [15:0] CFG_WORD,
	output logic CFG_VALID
);

	typedef struct packed {
		logic [ahipm_pkg::IN_W-1:0] s1;
		logic [ahipm_pkg::IN_W-1:0] s2;
		logic [ahipm_pkg::IN_W-1:0] s3;
		logic [ahipm_pkg::IN_W-1:0] flt;
		logic [2:0] settle;
		logic strapped;
		logic ser;
		logic sw;
		logic [ahipm_pkg::OS_W-1:0] os;
		logic burst;
		logic [ahipm_pkg::PAIR_W-1:0] word;
		logic half;
		logic [ahipm_pkg::RES_W-1:0] sa;
		logic [ahipm_pkg::RES_W-1:0] sb;
		logic [ahipm_pkg::RES_W-1:0] sin;
		logic [4:0] scnt;
		logic [ahipm_pkg::RES_W-1:0] cfg;
		logic cfg_v;
		logic [ahipm_pkg::BUS_W-1:0] db_o;
		logic [ahipm_pkg::BUS_W-1:0] db_oe;
	} ahipm_dev_st_t;

	ahipm_dev_st_t q, d;
	logic [ahipm_pkg::IN_W-1:0] raw;
	logic f_valid;
	logic f_pop;
	logic [ahipm_pkg::PAIR_W-1:0] f_data;
	logic cs_fall;
	logic cs_rise;
	logic clk_rise;
	logic wr_rise;
	logic frame;

	generate
		if (FIFO_DEPTH < 2) begin : g_chk
			$error("ahipm_dev: FIFO_DEPTH must be at least 2");
		end
	endgenerate

	// Pins gathered into one vector for the synchroniser.
	assign raw = {LINK.config_by_software, LINK.link_format_select,
		LINK.cs_n, LINK.sclk_rd, LINK.wr_burst, LINK.db};

	// Result buffer between the converter side and the link.
	ahipm_fifo #(
		.W(ahipm_pkg::PAIR_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(CLK),
		.rst_n(RST_N),
		.ce(CE),
		.in_valid(RES_VALID),
		.in_ready(RES_READY),
		.in_data(RES_DATA),
		.out_valid(f_valid),
		.out_ready(f_pop),
		.out_data(f_data)
	);

	// Next state of the whole pin controller.
	always_comb begin
		d = q;
		f_pop = 1'b0;
		d.cfg_v = 1'b0;
		d.s1 = raw;
		d.s2 = q.s1;
		d.s3 = q.s2;
		// A pin change counts once the last two stages agree.
		for (int i = 0; i < ahipm_pkg::IN_W; i++) begin
			if (q.s2[i] == q.s3[i]) begin
				d.flt[i] = q.s3[i];
			end
		end
		cs_fall = q.flt[ahipm_pkg::IN_CS] & ~d.flt[ahipm_pkg::IN_CS];
		cs_rise = ~q.flt[ahipm_pkg::IN_CS] & d.flt[ahipm_pkg::IN_CS];
		clk_rise = ~q.flt[ahipm_pkg::IN_SCLK] & d.flt[ahipm_pkg::IN_SCLK];
		wr_rise = ~q.flt[ahipm_pkg::IN_WR] & d.flt[ahipm_pkg::IN_WR];
		frame = q.strapped & ~d.flt[ahipm_pkg::IN_CS];
		// Straps are taken once, when the synchroniser has filled.
		if (!q.strapped) begin
			if (q.settle == ahipm_pkg::STRAP_SETTLE) begin
				d.strapped = 1'b1;
				d.ser = q.flt[ahipm_pkg::IN_FMT];
				d.sw = q.flt[ahipm_pkg::IN_SWM];
				if (q.flt[ahipm_pkg::IN_FMT] && !q.flt[ahipm_pkg::IN_SWM]) begin
					d.os = q.flt[ahipm_pkg::PIN_OS_LSB +: ahipm_pkg::OS_W];
				end
				if (!q.flt[ahipm_pkg::IN_SWM]) begin
					d.burst = q.flt[ahipm_pkg::IN_WR];
				end
			end else begin
				d.settle = q.settle + 3'h1;
			end
		end else if (!q.ser) begin
			// Each frame takes a fresh result pair if one waits.
			if (cs_fall) begin
				d.half = 1'b0;
				if (f_valid) begin
					d.word = f_data;
					f_pop = 1'b1;
				end
			end
			// Ending a read moves to the other channel.
			if (clk_rise && !q.flt[ahipm_pkg::IN_CS]) begin
				d.half = ~q.half;
			end
			if (q.sw && wr_rise && !q.flt[ahipm_pkg::IN_CS]) begin
				d.cfg = q.flt[ahipm_pkg::BUS_W-1:0];
				d.cfg_v = 1'b1;
			end
		end else begin
			if (cs_fall) begin
				d.scnt = '0;
				d.sin = '0;
				// An empty buffer resends the last pair, as in parallel.
				if (f_valid) begin
					d.word = f_data;
					f_pop = 1'b1;
				end
				d.sa = d.word[ahipm_pkg::PAIR_W-1:ahipm_pkg::RES_W];
				d.sb = d.word[ahipm_pkg::RES_W-1:0];
			end
			if (clk_rise && !q.flt[ahipm_pkg::IN_CS]) begin
				d.sa = {q.sa[ahipm_pkg::RES_W-2:0], 1'b0};
				d.sb = {q.sb[ahipm_pkg::RES_W-2:0], 1'b0};
				d.sin = {q.sin[ahipm_pkg::RES_W-2:0],
					q.flt[ahipm_pkg::PIN_SDI]};
				if (q.scnt != ahipm_pkg::SER_BITS) begin
					d.scnt = q.scnt + 5'h01;
				end
			end
			// A full serial word commits at the end of the frame.
			if (cs_rise && q.sw && q.scnt == ahipm_pkg::SER_BITS) begin
				d.cfg = q.sin;
				d.cfg_v = 1'b1;
			end
		end
		// Software mode takes its settings from the written word.
		if (q.strapped && q.sw && d.cfg_v) begin
			d.os = d.cfg[ahipm_pkg::CFGW_OS_LSB +: ahipm_pkg::OS_W];
			d.burst = d.cfg[ahipm_pkg::CFGW_BURST];
		end
		// drivers off unless a parallel read or a serial frame is under way.
		d.db_oe = '0;
		d.db_o = '0;
		if (q.strapped && !q.ser) begin
			if (!d.flt[ahipm_pkg::IN_CS] && !d.flt[ahipm_pkg::IN_SCLK]) begin
				d.db_oe = '1;
				d.db_o = d.half ? d.word[ahipm_pkg::RES_W-1:0] :
					d.word[ahipm_pkg::PAIR_W-1:ahipm_pkg::RES_W];
			end
		end else if (frame) begin
			// serial outputs on bits 12 and 11.
			d.db_oe[ahipm_pkg::PIN_SERIAL_OUT_A] = 1'b1;
			d.db_oe[ahipm_pkg::PIN_SERIAL_OUT_B] = 1'b1;
			d.db_o[ahipm_pkg::PIN_SERIAL_OUT_A] = d.sa[ahipm_pkg::RES_W-1];
			d.db_o[ahipm_pkg::PIN_SERIAL_OUT_B] = d.sb[ahipm_pkg::RES_W-1];
		end
	end

	// State register, frozen while the clock enable is low.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			q <= '0;
		end else if (CE) begin
			q <= d;
		end
	end

	// Every output but RES_READY is a field of the state register.
	assign LINK.db_dev_o = q.db_o;
	assign LINK.db_dev_oe = q.db_oe;
	assign STRAPS_TAKEN = q.strapped;
	assign SERIAL_MODE = q.ser;
	assign SW_CONFIG = q.sw;
	assign OVERSAMPLE_RATIO = q.os;
	assign BURST_ENABLE = q.burst;
	assign CFG_WORD = q.cfg;
	assign CFG_VALID = q.cfg_v;

endmodule

// [design/ahipm_host.sv]
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
module ahipm_host #(
	parameter int SCLK_HALF = ahipm_pkg::SCLK_HALF_CYC
) (
	// Clock, reset and clock enable.
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CE,
	// APB register port.
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Link towards the device.
	ahipm_link_if.host LINK
);

	// The half period must cover both synchronisers and the output register.
	generate
		if (SCLK_HALF < 8 || SCLK_HALF > 255) begin : g_chk
			$error("ahipm_host: SCLK_HALF must lie in 8..255");
		end
	endgenerate

	typedef struct packed {
		logic [15:0] s1;
		logic [15:0] s2;
		logic [15:0] s3;
		logic [15:0] flt;
		logic [ahipm_pkg::CTRL_W-1:0] ctrl;
		logic [15:0] cfg;
		logic [31:0] res;
		logic valid;
		logic wr_op;
		ahipm_pkg::ahipm_hstate_t st;
		logic [7:0] tmr;
		logic [3:0] cnt;
		logic [15:0] sh;
		logic cs_n;
		logic sclk_rd;
		logic wr_burst;
		logic [15:0] db_o;
		logic [15:0] db_oe;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} ahipm_host_st_t;

	ahipm_host_st_t q, d;
	logic access;
	logic ser;
	logic sw;

	// Register read decode.
	function automatic logic [32:0] rd_mux(input ahipm_host_st_t s,
		input logic [7:0] a);
		logic [32:0] r;
		r = '0;
		unique case (a)
			ahipm_pkg::ADDR_CTRL: r[ahipm_pkg::CTRL_W-1:0] = s.ctrl;
			ahipm_pkg::ADDR_CMD: r = '0;
			ahipm_pkg::ADDR_CFG: r[15:0] = s.cfg;
			ahipm_pkg::ADDR_STAT: begin
				r[ahipm_pkg::STAT_BUSY] = (s.st != ahipm_pkg::HS_IDLE);
				r[ahipm_pkg::STAT_VALID] = s.valid;
			end
			ahipm_pkg::ADDR_RES: r[31:0] = s.res;
			default: r[32] = 1'b1;
		endcase
		return r;
	endfunction

	// Next state of the bus slave and the link sequencer.
	always_comb begin
		d = q;
		d.s1 = LINK.db;
		d.s2 = q.s1;
		d.s3 = q.s2;
		for (int i = 0; i < 16; i++) begin
			if (q.s2[i] == q.s3[i]) begin
				d.flt[i] = q.s3[i];
			end
		end
		ser = q.ctrl[ahipm_pkg::CTRL_SER];
		sw = q.ctrl[ahipm_pkg::CTRL_SW];
		access = PSEL & PENABLE;
		// One wait state, then the answer stands for one edge.
		d.pready = access & ~q.pready;
		if (access && !q.pready) begin
			{d.pslverr, d.prdata} = rd_mux(q, PADDR);
		end else begin
			d.pslverr = 1'b0;
		end
		if (access && q.pready && PWRITE) begin
			unique case (PADDR)
				ahipm_pkg::ADDR_CTRL: begin
					d.ctrl = PWDATA[ahipm_pkg::CTRL_W-1:0];
				end
				ahipm_pkg::ADDR_CFG: d.cfg = PWDATA[15:0];
				ahipm_pkg::ADDR_CMD: begin
					if (q.st == ahipm_pkg::HS_IDLE &&
						(PWDATA[ahipm_pkg::CMD_READ] ||
						PWDATA[ahipm_pkg::CMD_WRITE])) begin
						d.wr_op = PWDATA[ahipm_pkg::CMD_WRITE];
						d.valid = 1'b0;
						d.sh = PWDATA[ahipm_pkg::CMD_WRITE] ? q.cfg : '0;
						d.cnt = '0;
						d.tmr = 8'(SCLK_HALF - 1);
						d.cs_n = 1'b0;
						d.st = ahipm_pkg::HS_LEAD;
					end
				end
				default: d.ctrl = q.ctrl;
			endcase
		end
		// Link sequencer, every phase lasts one half period.
		if (q.st != ahipm_pkg::HS_IDLE && q.tmr != 8'h00) begin
			d.tmr = q.tmr - 8'h01;
		end else begin
			if (q.st != ahipm_pkg::HS_IDLE) begin
				d.tmr = 8'(SCLK_HALF - 1);
			end
			unique case (q.st)
				ahipm_pkg::HS_IDLE: d.st = d.st;
				ahipm_pkg::HS_LEAD, ahipm_pkg::HS_SHI: begin
					if (ser) begin
						if (q.st == ahipm_pkg::HS_SHI && q.cnt == ahipm_pkg::SER_LAST) begin
							d.cs_n = 1'b1;
							d.st = ahipm_pkg::HS_TAIL;
						end else begin
							// Take a bit, present the next input bit.
							// The filter's next value is used: the
							// round trip takes the whole half period.
							d.res[31:16] = {q.res[30:16], d.flt[ahipm_pkg::PIN_SERIAL_OUT_A]};
							d.res[15:0] = {q.res[14:0], d.flt[ahipm_pkg::PIN_SERIAL_OUT_B]};
							if (q.st == ahipm_pkg::HS_SHI) begin
								d.cnt = q.cnt + 4'h1;
								d.sh = {q.sh[14:0], 1'b0};
							end
							d.sclk_rd = 1'b0;
							d.st = ahipm_pkg::HS_SLO;
						end
					end else begin
						d.st = ahipm_pkg::HS_PLO;
					end
				end
				ahipm_pkg::HS_SLO: begin
					d.sclk_rd = 1'b1;
					d.st = ahipm_pkg::HS_SHI;
				end
				ahipm_pkg::HS_PLO: begin
					if (!q.wr_op) begin
						if (q.cnt == 4'h0) begin
							d.res[31:16] = d.flt;
						end else begin
							d.res[15:0] = d.flt;
						end
					end
					d.st = ahipm_pkg::HS_PHI;
				end
				ahipm_pkg::HS_PHI: begin
					if (!q.wr_op && q.cnt == 4'h0) begin
						d.cnt = 4'h1;
						d.st = ahipm_pkg::HS_PLO;
					end else begin
						d.cs_n = 1'b1;
						d.st = ahipm_pkg::HS_TAIL;
					end
				end
				ahipm_pkg::HS_TAIL: begin
					d.valid = ~q.wr_op;
					d.st = ahipm_pkg::HS_IDLE;
				end
				default: d.st = ahipm_pkg::HS_IDLE;
			endcase
		end
		// Pin levels for the mode in force.
		d.db_o = '0;
		d.db_oe = '0;
		if (ser) begin
			d.db_oe[ahipm_pkg::PIN_GND0] = 1'b1;
			d.db_oe[ahipm_pkg::PIN_GND1] = 1'b1;
			d.db_oe[ahipm_pkg::PIN_SDI] = 1'b1;
			d.db_o[ahipm_pkg::PIN_SDI] = sw & d.wr_op & ~d.cs_n & d.sh[15];
			d.db_oe[ahipm_pkg::PIN_OS_LSB +: ahipm_pkg::OS_W] = '1;
			if (!sw) begin
				d.db_o[ahipm_pkg::PIN_OS_LSB +: ahipm_pkg::OS_W] =
					q.ctrl[ahipm_pkg::CTRL_OS_LSB +: ahipm_pkg::OS_W];
			end
		end else if (d.wr_op && (d.st == ahipm_pkg::HS_PLO ||
			d.st == ahipm_pkg::HS_PHI)) begin
			d.db_oe = '1;
			d.db_o = q.cfg;
		end
		// write strobe, burst strap or ground.
		if (!sw) begin
			d.wr_burst = q.ctrl[ahipm_pkg::CTRL_BURST];
		end else if (ser) begin
			d.wr_burst = 1'b0;
		end else begin
			d.wr_burst = ~(d.wr_op && d.st == ahipm_pkg::HS_PLO);
		end
		// read strobe in parallel, clock held in serial.
		if (!ser) begin
			d.sclk_rd = ~(~d.wr_op && d.st == ahipm_pkg::HS_PLO);
		end
	end

	// State register; select and read strobe idle high after reset, write strobe low.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			q <= '0;
			q.st <= ahipm_pkg::HS_IDLE;
			q.cs_n <= 1'b1;
			q.sclk_rd <= 1'b1;
		end else if (CE) begin
			q <= d;
		end
	end

	// Every output is a field of the state register.
	assign LINK.link_format_select = q.ctrl[ahipm_pkg::CTRL_SER];
	assign LINK.config_by_software = q.ctrl[ahipm_pkg::CTRL_SW];
	assign LINK.cs_n = q.cs_n;
	assign LINK.sclk_rd = q.sclk_rd;
	assign LINK.wr_burst = q.wr_burst;
	assign LINK.db_host_o = q.db_o;
	assign LINK.db_host_oe = q.db_oe;
	assign PRDATA = q.prdata;
	assign PREADY = q.pready;
	assign PSLVERR = q.pslverr;

endmodule

// [sim/ahipm_link_properties.sv]
`timescale 1ns/100ps
// Watches pin ownership and framing on the link between the two ends.
module ahipm_link_properties (
	// Device clock and reset.
	input wire logic CLK,
	input wire logic RST_N,
	// Link signals.
	input wire logic link_format_select,
	input wire logic config_by_software,
	input wire logic cs_n,
	input wire logic sclk_rd,
	input wire logic wr_burst,
	input wire logic [15:0] db_dev_o,
	input wire logic [15:0] db_dev_oe,
	input wire logic [15:0] db
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	// Settled link phases, long enough for the pin synchroniser.
	sequence s_idle; cs_n [*8]; endsequence
	sequence s_par_read;
		(!link_format_select && !cs_n && !sclk_rd) [*8];
	endsequence
	sequence s_par_rd_high; (!link_format_select && sclk_rd) [*8]; endsequence
	sequence s_ser_frame; (link_format_select && !cs_n) [*8]; endsequence
	sequence s_ser_hold;
		(link_format_select && !cs_n && $stable(sclk_rd)) [*8];
	endsequence
	sequence s_ser_start; link_format_select && $fell(cs_n); endsequence

	property p_idle_release; s_idle |-> db_dev_oe == 16'h0000; endproperty
	property p_par_drive; s_par_read |-> db_dev_oe == 16'hFFFF; endproperty
	property p_par_release; s_par_rd_high |-> db_dev_oe == 16'h0000; endproperty
	property p_par_whole;
		!link_format_select |-> db_dev_oe inside {16'h0000, 16'hFFFF};
	endproperty
	property p_ser_pins; s_ser_frame |-> db_dev_oe == 16'h1800; endproperty
	property p_ser_start;
		s_ser_start |-> ##[1:8] (db_dev_oe[12] && db_dev_oe[11]);
	endproperty
	property p_ser_shift; s_ser_hold |-> $stable(db_dev_o[12:11]); endproperty
	property p_clk_idle; cs_n && $past(cs_n) |-> sclk_rd; endproperty
	property p_ser_ground; link_format_select |-> db[9:8] == 2'b00; endproperty
	property p_sw_ground;
		link_format_select && config_by_software |->
			!wr_burst && db[15:13] == 3'b000;
	endproperty
	property p_hw_sdi;
		link_format_select && !config_by_software |-> !db[10];
	endproperty

	a_idle_release: assert property (p_idle_release)
		else $error("Device drives the link outside a frame.");
	a_par_drive: assert property (p_par_drive)
		else $error("Parallel read without the bus driven.");
	a_par_release: assert property (p_par_release)
		else $error("Parallel bus driven with read high.");
	a_par_whole: assert property (p_par_whole)
		else $error("Parallel bus partly driven.");
	a_ser_pins: assert property (p_ser_pins)
		else $error("Serial frame drives the wrong pins.");
	a_ser_start: assert property (p_ser_start)
		else $error("Serial outputs not driven after select fall.");
	a_ser_shift: assert property (p_ser_shift)
		else $error("Serial output moved without a clock edge.");
	a_clk_idle: assert property (p_clk_idle)
		else $error("Serial clock moves outside a frame.");
	a_ser_ground: assert property (p_ser_ground)
		else $error("Low bus bits not grounded in serial mode.");
	a_sw_ground: assert property (p_sw_ground)
		else $error("Strap pins not grounded in software serial.");
	a_hw_sdi: assert property (p_hw_sdi)
		else $error("Serial input not grounded in hardware serial.");
endmodule

// [sim/adc_host_interface_pin_modes_tb.sv]
`timescale 1ns/100ps
// Runs every link mode through the host registers and the result stream.
module adc_host_interface_pin_modes_tb;
	logic clk, host_rst_n, dev_rst_n, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, res_data;
	logic res_valid, res_ready, straps_taken, serial_mode, sw_config;
	logic burst_enable, cfg_valid, cfg_seen;
	logic [2:0] os_ratio;
	logic [15:0] cfg_word;
	int bad_count, check_count;
	ahipm_link_if link ();

	ahipm_dev ahipm_dev_inst (.CLK(clk), .RST_N(dev_rst_n), .CE(1'b1),
		.LINK(link.dev), .RES_VALID(res_valid), .RES_READY(res_ready),
		.RES_DATA(res_data), .STRAPS_TAKEN(straps_taken),
		.SERIAL_MODE(serial_mode), .SW_CONFIG(sw_config),
		.OVERSAMPLE_RATIO(os_ratio), .BURST_ENABLE(burst_enable),
		.CFG_WORD(cfg_word), .CFG_VALID(cfg_valid));
	ahipm_host ahipm_host_inst (.CLK(clk), .RST_N(host_rst_n), .CE(1'b1),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .LINK(link.host));
	ahipm_link_properties ahipm_link_properties_inst (.CLK(clk),
		.RST_N(dev_rst_n), .link_format_select(link.link_format_select),
		.config_by_software(link.config_by_software), .cs_n(link.cs_n),
		.sclk_rd(link.sclk_rd), .wr_burst(link.wr_burst),
		.db_dev_o(link.db_dev_o), .db_dev_oe(link.db_dev_oe), .db(link.db));

	// Clock at 100 MHz.
	initial clk = 1'b0;
	always #5 clk = ~clk;

	// Remembers a configuration pulse from the device.
	always @(posedge clk) if (cfg_valid === 1'b1) cfg_seen <= 1'b1;

	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic stop_test();
		$display("Checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic timed_out(input string name);
		bad_count++;
		$display("Error %s expected answer seen timeout", name);
		stop_test();
	endtask

	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic err);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) timed_out("pready");
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic poll_idle(input logic need_valid);
		logic [31:0] s;
		logic e;
		int n;
		n = 0;
		do begin
			apb(1'b0, ahipm_pkg::ADDR_STAT, 32'h0, s, e);
			n++;
		end while ((s[0] !== 1'b0 || (need_valid && s[1] !== 1'b1)) && n < 400);
		if (n >= 400) timed_out("status");
	endtask

	task automatic push(input logic [31:0] d);
		int n;
		res_valid <= 1'b1;
		res_data <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (res_ready !== 1'b1 && n < 50);
		if (n >= 50) timed_out("res_ready");
	endtask

	task automatic read_frame(input logic ser, input logic [31:0] exp);
		logic [31:0] r;
		logic e;
		int n;
		wr_reg(ahipm_pkg::ADDR_CMD, 32'h1);
		n = 0;
		while ((link.cs_n !== 1'b0 || (!ser && link.sclk_rd !== 1'b0))
			&& n < 100) begin
			@(posedge clk);
			n++;
		end
		if (n >= 100) timed_out("frame start");
		repeat (7) @(posedge clk);
		if (ser) begin
			check("serial A msb", link.db[12], exp[31]);
			check("serial B msb", link.db[11], exp[15]);
		end else begin
			check("parallel A", link.db, exp[31:16]);
		end
		poll_idle(1'b1);
		apb(1'b0, ahipm_pkg::ADDR_RES, 32'h0, r, e);
		check("result pair", r, exp);
	endtask

	task automatic cfg_write(input logic [15:0] cfg);
		logic [31:0] r;
		logic e;
		int n;
		wr_reg(ahipm_pkg::ADDR_CFG, {16'h0, cfg});
		cfg_seen <= 1'b0;
		wr_reg(ahipm_pkg::ADDR_CMD, 32'h2);
		n = 0;
		while (cfg_seen !== 1'b1 && n < 1000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 1000) timed_out("config pulse");
		poll_idle(1'b0);
		check("config word", cfg_word, cfg);
		check("config ratio", os_ratio, cfg[2:0]);
		check("config burst", burst_enable, cfg[3]);
	endtask

	// Straps, buffer fill and drain, and frames in one link mode.
	task automatic run_mode(input logic [5:0] ctrl, input logic [15:0] cfg);
		logic hw_ser;
		hw_ser = ctrl[0] && !ctrl[1];
		dev_rst_n <= 1'b0;
		wr_reg(ahipm_pkg::ADDR_CTRL, {26'h0, ctrl});
		repeat (10) @(posedge clk);
		dev_rst_n <= 1'b1;
		repeat (20) @(posedge clk);
		check("straps taken", straps_taken, 1'b1);
		check("serial mode", serial_mode, ctrl[0]);
		check("software mode", sw_config, ctrl[1]);
		check("ratio strap", os_ratio, hw_ser ? ctrl[5:3] : 3'h0);
		check("burst strap", burst_enable, !ctrl[1] && ctrl[2]);
		if (!ctrl[1]) begin
			wr_reg(ahipm_pkg::ADDR_CTRL,
				{26'h0, ctrl ^ (ctrl[0] ? 6'h3C : 6'h04)});
			repeat (20) @(posedge clk);
			check("ratio held", os_ratio, hw_ser ? ctrl[5:3] : 3'h0);
			check("burst held", burst_enable, ctrl[2]);
		end
		for (int k = 0; k < 4; k++) push(32'hA5C3_3C5A + k * 32'h1357_2468);
		res_valid <= 1'b0;
		repeat (2) @(posedge clk);
		check("buffer full", res_ready, 1'b0);
		for (int k = 0; k < 5; k++)
			read_frame(ctrl[0], 32'hA5C3_3C5A + (k < 4 ? k : 3) * 32'h1357_2468);
		if (ctrl[1]) cfg_write(cfg);
	endtask

	// Main sequence over all four modes, then an unmapped access.
	initial begin
		logic [31:0] r;
		logic e;
		host_rst_n = 1'b0;
		dev_rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		res_valid = 1'b0;
		res_data = 32'h0;
		cfg_seen = 1'b0;
		bad_count = 0;
		check_count = 0;
		repeat (3) @(posedge clk);
		host_rst_n <= 1'b1;
		run_mode(6'h04, 16'h0000);
		run_mode(6'h2D, 16'h0000);
		run_mode(6'h11, 16'h0000);
		run_mode(6'h02, 16'h800D);
		run_mode(6'h03, 16'h5A32);
		apb(1'b0, 8'h14, 32'h0, r, e);
		check("unmapped error", e, 1'b1);
		check("unmapped data", r, 32'h0);
		stop_test();
	end
endmodule
